/* File: verilog/bcpr_pin_routing.sv */
// port R pin routing and module enable gating for the bridge configurations
`default_nettype none

module bcpr_pin_routing (
   input  wire logic                     clk,
   input  wire logic                     sys_rst,
   input  wire logic [7:0]               moduleRoute,      // module_routing_register value
   input  wire bcpr_pkg::bcpr_enable_type requestEnable,   // software module enables
   input  wire logic [5:0]               cardAddrEnable,   // address enables 5..10
   input  wire logic [5:0]               cardAddrOut,      // card address 5..10
   input  wire logic [3:0]               timerOut,         // timer channels 4..7
   input  wire logic [3:0]               timerOe,
   input  wire logic                     serialTx,
   input  wire logic [7:0]               gpioOut,
   input  wire logic [7:0]               gpioOe,
   input  wire logic [7:0]               portRIn,
   output logic [7:0]                    portROut,
   output logic [7:0]                    portROe,
   output logic [7:0]                    gpioIn,
   output logic [3:0]                    timerIn,
   output logic                          serialRx,
   output bcpr_pkg::bcpr_config_type     activeConfig,
   output bcpr_pkg::bcpr_enable_type     grantEnable,
   output logic                          configError
);

   // configuration from routing value and requested enables
   function automatic bcpr_pkg::bcpr_config_type decodeConfig(
      input logic [7:0] route,
      input bcpr_pkg::bcpr_enable_type req);
      bcpr_pkg::bcpr_config_type cfg;
      cfg = bcpr_pkg::BCPR_CFG_INVALID;
      if (route == bcpr_pkg::ROUTE_DISK_CARD) begin
         cfg = bcpr_pkg::BCPR_CFG_DISK_CARD;
      end else if (route == bcpr_pkg::ROUTE_FLASH && !req.card) begin
         cfg = bcpr_pkg::BCPR_CFG_DISK_FLASH;
      end else if (route == bcpr_pkg::ROUTE_FLASH && !req.disk) begin
         cfg = bcpr_pkg::BCPR_CFG_CARD_FLASH;
      end
      return cfg;
   endfunction

   // owner of one shared port bit (2..7)
   function automatic bcpr_pkg::bcpr_owner_type pinOwner(
      input int bitIdx,
      input logic cardCfg,
      input bcpr_pkg::bcpr_enable_type grant,
      input logic [5:0] cae);
      bcpr_pkg::bcpr_owner_type own;
      int k;
      own = bcpr_pkg::BCPR_OWN_GPIO;
      k = bitIdx - bcpr_pkg::SHARED_LSB;
      if (cardCfg && grant.card && cae[k]) begin
         own = bcpr_pkg::BCPR_OWN_CARD;
      end else if (bitIdx >= bcpr_pkg::TIMER_LSB && cardCfg && grant.counter
                   && cae[5:bcpr_pkg::TIMER_EN_LSB] == 4'h0) begin
         own = bcpr_pkg::BCPR_OWN_TIMER;
      end else if (bitIdx < bcpr_pkg::TIMER_LSB && cardCfg && grant.serial
                   && cae[bcpr_pkg::SERIAL_EN_MSB:0] == 2'h0) begin
         own = bcpr_pkg::BCPR_OWN_SERIAL;
      end
      return own;
   endfunction

   bcpr_pkg::bcpr_config_type next_activeConfig;
   bcpr_pkg::bcpr_enable_type next_grantEnable;
   logic                      next_configError;
   logic [7:0]                next_portROut;
   logic [7:0]                next_portROe;
   logic [7:0]                next_gpioIn;
   logic [3:0]                next_timerIn;
   logic                      next_serialRx;
   logic                      cardCfg;
   bcpr_pkg::bcpr_owner_type  owner [bcpr_pkg::PORT_WIDTH];

   // configuration decode and enable gating
   always_comb begin
      next_activeConfig = decodeConfig(moduleRoute, requestEnable);
      next_grantEnable = bcpr_pkg::ENABLE_RESET;
      next_grantEnable.counter = requestEnable.counter;
      next_grantEnable.serial = requestEnable.serial;
      case (next_activeConfig)
         bcpr_pkg::BCPR_CFG_DISK_CARD: begin
            next_grantEnable.disk = requestEnable.disk;
            next_grantEnable.card = requestEnable.card;
         end
         bcpr_pkg::BCPR_CFG_DISK_FLASH: begin
            next_grantEnable.disk = requestEnable.disk;
            next_grantEnable.smart = requestEnable.smart;
            next_grantEnable.secure = requestEnable.secure;
            next_grantEnable.stick = requestEnable.stick;
         end
         bcpr_pkg::BCPR_CFG_CARD_FLASH: begin
            next_grantEnable.card = requestEnable.card;
            next_grantEnable.smart = requestEnable.smart;
            next_grantEnable.secure = requestEnable.secure;
            next_grantEnable.stick = requestEnable.stick;
         end
         default: begin
            next_grantEnable.disk = 1'b0;   // invalid: only counter and serial pass
         end
      endcase
      // any request the configuration refuses is flagged
      next_configError = (next_activeConfig == bcpr_pkg::BCPR_CFG_INVALID)
                         || (requestEnable != next_grantEnable);
   end

   // per-pin owner and pin drive
   always_comb begin
      cardCfg = (next_activeConfig == bcpr_pkg::BCPR_CFG_DISK_CARD)
                || (next_activeConfig == bcpr_pkg::BCPR_CFG_CARD_FLASH);
      next_portROut = gpioOut;
      next_portROe = gpioOe;
      next_gpioIn = portRIn;
      next_timerIn = bcpr_pkg::TIMER_RESET;
      next_serialRx = bcpr_pkg::SERIAL_IDLE;
      for (int b = 0; b < bcpr_pkg::PORT_WIDTH; b++) begin
         owner[b] = bcpr_pkg::BCPR_OWN_GPIO;
      end
      for (int b = bcpr_pkg::SHARED_LSB; b < bcpr_pkg::PORT_WIDTH; b++) begin
         owner[b] = pinOwner(b, cardCfg, next_grantEnable, cardAddrEnable);
         case (owner[b])
            bcpr_pkg::BCPR_OWN_CARD: begin
               next_portROut[b] = cardAddrOut[b - bcpr_pkg::SHARED_LSB];
               next_portROe[b] = 1'b1;
            end
            bcpr_pkg::BCPR_OWN_TIMER: begin
               next_portROut[b] = timerOut[2'(b - bcpr_pkg::TIMER_LSB)];
               next_portROe[b] = timerOe[2'(b - bcpr_pkg::TIMER_LSB)];
               next_timerIn[2'(b - bcpr_pkg::TIMER_LSB)] = portRIn[b];
            end
            bcpr_pkg::BCPR_OWN_SERIAL: begin
               if (b == bcpr_pkg::SERIAL_TX_BIT) begin
                  next_portROut[b] = serialTx;
                  next_portROe[b] = 1'b1;
               end else begin
                  next_portROut[b] = 1'b0;
                  next_portROe[b] = 1'b0;
                  next_serialRx = portRIn[b];
               end
            end
            default: begin
               next_portROut[b] = gpioOut[b];
               next_portROe[b] = gpioOe[b];
            end
         endcase
      end
   end

   // registered outputs
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         activeConfig <= bcpr_pkg::BCPR_CFG_DISK_FLASH;
         grantEnable <= bcpr_pkg::ENABLE_RESET;
         configError <= 1'b0;
         portROut <= bcpr_pkg::PORT_RESET;
         portROe <= bcpr_pkg::PORT_RESET;
         gpioIn <= bcpr_pkg::PORT_RESET;
         timerIn <= bcpr_pkg::TIMER_RESET;
         serialRx <= bcpr_pkg::SERIAL_IDLE;
      end else begin
         activeConfig <= next_activeConfig;
         grantEnable <= next_grantEnable;
         configError <= next_configError;
         portROut <= next_portROut;
         portROe <= next_portROe;
         gpioIn <= next_gpioIn;
         timerIn <= next_timerIn;
         serialRx <= next_serialRx;
      end
   end

   // checks on the routing outcome
   a_route_card_cfg: assert property (@(posedge clk) disable iff (sys_rst)
      !sys_rst && moduleRoute == bcpr_pkg::ROUTE_DISK_CARD |=>
      activeConfig == bcpr_pkg::BCPR_CFG_DISK_CARD
      && !grantEnable.smart && !grantEnable.secure && !grantEnable.stick)
      else $error("disk-card config let a flash controller through");

   a_flash_no_card: assert property (@(posedge clk) disable iff (sys_rst)
      activeConfig == bcpr_pkg::BCPR_CFG_DISK_FLASH |-> !grantEnable.card)
      else $error("card controller granted in disk-flash config");

   a_flash_no_disk: assert property (@(posedge clk) disable iff (sys_rst)
      (!sys_rst && moduleRoute == bcpr_pkg::ROUTE_FLASH
       && requestEnable.card && !requestEnable.disk)
      |=> activeConfig == bcpr_pkg::BCPR_CFG_CARD_FLASH && !grantEnable.disk
      && grantEnable.card)
      else $error("card-flash config not taken");

   a_bad_route_err: assert property (@(posedge clk) disable iff (sys_rst)
      (!sys_rst && moduleRoute != bcpr_pkg::ROUTE_DISK_CARD
       && moduleRoute != bcpr_pkg::ROUTE_FLASH)
      |=> configError && activeConfig == bcpr_pkg::BCPR_CFG_INVALID)
      else $error("unknown routing value not flagged");

   a_timer_pins: assert property (@(posedge clk) disable iff (sys_rst)
      (!sys_rst && moduleRoute == bcpr_pkg::ROUTE_DISK_CARD && requestEnable.counter
       && cardAddrEnable[5:2] == 4'h0) |=>
      portROut[7:4] == $past(timerOut) && portROe[7:4] == $past(timerOe)
      && timerIn == $past(portRIn[7:4]))
      else $error("timer channels not on port R upper bits");

   a_serial_pins: assert property (@(posedge clk) disable iff (sys_rst)
      (!sys_rst && moduleRoute == bcpr_pkg::ROUTE_DISK_CARD && requestEnable.serial
       && cardAddrEnable[1:0] == 2'h0) |=>
      portROut[3] == $past(serialTx) && portROe[3:2] == 2'b10
      && serialRx == $past(portRIn[2]))
      else $error("serial pins not on port R bits 3 and 2");

   a_card_owns_pin: assert property (@(posedge clk) disable iff (sys_rst)
      (!sys_rst && moduleRoute == bcpr_pkg::ROUTE_DISK_CARD && requestEnable.card
       && cardAddrEnable[5]) |=>
      portROut[7] == $past(cardAddrOut[5]) && portROe[7] && timerIn == 4'h0)
      else $error("set address enable did not give pin to card");

   a_gpio_fallback: assert property (@(posedge clk) disable iff (sys_rst)
      (!sys_rst && !requestEnable.card && !requestEnable.counter && !requestEnable.serial) |=>
      portROut == $past(gpioOut) && portROe == $past(gpioOe) && serialRx)
      else $error("idle modules did not release pins to gpio");

endmodule

`default_nettype wire

/* File: shared/bcpr_pkg.sv */
// constants and types for the bridge configuration pin routing block
`default_nettype none

package bcpr_pkg;

   // routing register values
   localparam logic [7:0] ROUTE_DISK_CARD = 8'h10;
   localparam logic [7:0] ROUTE_FLASH     = 8'h00;

   // port and pin layout
   localparam int PORT_WIDTH     = 8;
   localparam int CARD_ADDR_BITS = 6;   // address enables 5..10
   localparam int SHARED_LSB     = 2;   // port bit of address enable 5
   localparam int TIMER_LSB      = 4;   // port bit of timer channel 4
   localparam int TIMER_CHANNELS = 4;
   localparam int SERIAL_TX_BIT  = 3;
   localparam int SERIAL_RX_BIT  = 2;
   localparam int TIMER_EN_LSB   = 2;   // address-enable index of bit 7..4 group
   localparam int SERIAL_EN_MSB  = 1;   // address-enable index of bit 3..2 group

   // reset and idle values
   localparam logic [7:0] PORT_RESET  = 8'h00;
   localparam logic [3:0] TIMER_RESET = 4'h0;
   localparam logic       SERIAL_IDLE = 1'b1;

   // which bridge configuration is in force
   typedef enum logic [1:0] {
      BCPR_CFG_DISK_CARD,
      BCPR_CFG_DISK_FLASH,
      BCPR_CFG_CARD_FLASH,
      BCPR_CFG_INVALID
   } bcpr_config_type;

   // owner of one port R pin
   typedef enum logic [1:0] {
      BCPR_OWN_GPIO,
      BCPR_OWN_TIMER,
      BCPR_OWN_SERIAL,
      BCPR_OWN_CARD
   } bcpr_owner_type;

   // module enables, requested or granted
   typedef struct packed {
      logic disk;
      logic card;
      logic smart;
      logic secure;
      logic stick;
      logic counter;
      logic serial;
   } bcpr_enable_type;

   localparam bcpr_enable_type ENABLE_RESET = '0;

endpackage

`default_nettype wire

/* File: tb/bcpr_pin_partner.sv */
// behavioural model of the far-side devices wired to port R
`default_nettype none

module bcpr_pin_partner (
   input  wire logic       clk,
   input  wire logic [7:0] portROut,
   input  wire logic [7:0] portROe,
   input  wire logic [7:0] extVal,
   input  wire logic [7:0] extOe,
   output logic      [7:0] portRIn
);
   timeunit 1ns;
   timeprecision 1ps;

   logic [7:0] floatPat = 8'h55;

   // a pin nobody drives flips every cycle, so a stale level never reads back as valid
   always @(posedge clk) begin
      floatPat <= ~floatPat;
   end

   // wire level: block drive first, then the far device, else the floating pattern
   always_comb begin
      for (int b = 0; b < 8; b++) begin
         portRIn[b] = portROe[b] ? portROut[b] : (extOe[b] ? extVal[b] : floatPat[b]);
      end
   end
endmodule

`default_nettype wire

/* File: tb/bcpr_pin_routing_test.sv */
// self-checking testbench for port R routing and module enable gating
`default_nettype none

module bcpr_pin_routing_test;
   timeunit 1ns;
   timeprecision 1ps;

   logic                      clk = 1'b0;
   logic                      sysRst = 1'b1;
   logic [7:0]                route = 8'h00;
   bcpr_pkg::bcpr_enable_type req = '0;
   logic [5:0]                cae = 6'h00;
   logic [3:0]                tOut = 4'h0;
   logic [3:0]                tOe = 4'h0;
   logic                      sTx = 1'b1;
   logic [7:0]                pIn;
   logic [7:0]                pOut;
   logic [7:0]                pOe;
   logic [7:0]                gIn;
   logic [3:0]                tIn;
   logic                      sRx;
   bcpr_pkg::bcpr_config_type cfg;
   bcpr_pkg::bcpr_enable_type grant;
   logic                      cfgErr;
   int                        errCount = 0;
   int                        checkCount = 0;
   int                        cycles = 0;
   logic [7:0] tRoute [6] = '{8'h10, 8'h10, 8'h00, 8'h00, 8'h00, 8'h55};
   logic [6:0] tReq   [6] = '{7'h63, 7'h33, 7'h5C, 7'h3C, 7'h60, 7'h63};
   logic [6:0] tGrant [6] = '{7'h63, 7'h23, 7'h5C, 7'h3C, 7'h00, 7'h03};
   logic [1:0] tCfg   [6] = '{2'h0, 2'h0, 2'h1, 2'h2, 2'h3, 2'h3};
   logic       tErr   [6] = '{1'b0, 1'b1, 1'b0, 1'b0, 1'b1, 1'b1};

   bcpr_pin_routing i_dut (
      .clk(clk), .sys_rst(sysRst), .moduleRoute(route), .requestEnable(req),
      .cardAddrEnable(cae), .cardAddrOut(6'h2A), .timerOut(tOut), .timerOe(tOe),
      .serialTx(sTx), .gpioOut(8'hC5), .gpioOe(8'h96), .portRIn(pIn), .portROut(pOut),
      .portROe(pOe), .gpioIn(gIn), .timerIn(tIn), .serialRx(sRx), .activeConfig(cfg),
      .grantEnable(grant), .configError(cfgErr));

   bcpr_pin_partner i_far (
      .clk(clk), .portROut(pOut), .portROe(pOe), .extVal(8'h6B), .extOe(8'hFC),
      .portRIn(pIn));

   // 40 MHz clock
   initial begin
      forever #12.5 clk = ~clk;
   end

   // cut a hang short
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == 2000) begin
         errCount++;
         endOfTest();
      end
   end

   task automatic endOfTest();
      if (errCount == 0 && checkCount > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask

   task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
      checkCount++;
      if (seen !== exp) begin
         errCount++;
         $display("BAD %s expected %h seen %h", name, exp, seen);
      end
   endtask

   // drive one input set, then let the pins and their read-back settle
   task automatic put(input logic [7:0] r, input logic [6:0] q, input logic [5:0] c,
                      input logic [3:0] to, input logic [3:0] te, input logic tx);
      @(posedge clk);
      route <= r;
      req <= bcpr_pkg::bcpr_enable_type'(q);
      cae <= c;
      tOut <= to;
      tOe <= te;
      sTx <= tx;
      repeat (2) @(posedge clk);
      #1;
   endtask

   // main sequence
   initial begin
      repeat (8) @(posedge clk);
      sysRst <= 1'b0;
      #1;
      chk("reset oe", pOe, 8'h00);
      chk("reset out", pOut, 8'h00);
      chk("reset gpio in", gIn, 8'h00);
      chk("reset timer in", {4'h0, tIn}, 8'h00);
      chk("reset rx cfg err", {4'h0, sRx, cfg, cfgErr}, 8'h0A);
      chk("reset grant", {1'b0, grant}, 8'h00);
      // every bridge configuration, legal and refused requests
      for (int i = 0; i < 6; i++) begin
         put(tRoute[i], tReq[i], 6'h00, 4'h0, 4'h0, 1'b1);
         chk("config", {6'h00, cfg}, {6'h00, tCfg[i]});
         chk("grant", {1'b0, grant}, {1'b0, tGrant[i]});
         chk("error", {7'h00, cfgErr}, {7'h00, tErr[i]});
      end
      // timer on the upper pins, mixed drive enables
      put(8'h10, 7'h22, 6'h00, 4'hA, 4'h5, 1'b1);
      chk("timer out", {pOe[7:4], pOut[7:4]}, 8'h5A);
      chk("timer in", {4'h0, tIn}, 8'h02);
      // one address enable set: bit 7 to card, rest gpio, timer off the pins
      put(8'h10, 7'h22, 6'h20, 4'hA, 4'h5, 1'b1);
      chk("partial addr", {pOe[7:4], pOut[7:4]}, 8'h9C);
      chk("partial timer in", {4'h0, tIn}, 8'h00);
      // no card configuration: timer stays off port R
      put(8'h00, 7'h02, 6'h00, 4'hA, 4'h5, 1'b1);
      chk("flash timer", {pOe[7:4], pOut[7:4]}, 8'h9C);
      // serial in both card configurations, both transmit levels
      for (int i = 0; i < 4; i++) begin
         put(i[1] ? 8'h00 : 8'h10, 7'h21, 6'h00, 4'h0, 4'h0, i[0]);
         chk("serial pins", {4'h0, pOe[3:2], pOut[3:2]}, {6'h02, i[0], 1'b0});
         chk("serial rx", {7'h00, sRx}, 8'h00);
      end
      // address enable 5 takes bit 2, bit 3 falls back to gpio
      put(8'h10, 7'h21, 6'h01, 4'h0, 4'h0, 1'b1);
      chk("serial partial", {4'h0, pOe[3:2], pOut[3:2]}, 8'h04);
      chk("serial idle rx", {7'h00, sRx}, 8'h01);
      // nothing enabled: every pin is general purpose
      put(8'h00, 7'h00, 6'h00, 4'h0, 4'h0, 1'b1);
      chk("gpio out", pOut, 8'hC5);
      chk("gpio oe", pOe, 8'h96);
      chk("gpio in", gIn & 8'hFE, 8'hEC);
      endOfTest();
   end
endmodule

`default_nettype wire
